//--- pkg/mcrb_pkg.sv
// Constants for the miscellaneous configuration register bank
//
// Behaviour
// - Alternate slot selects map inputs 0 to 11
// - SPI address shown as two read-only bytes
// - SPI command byte captured, read-only
// - Port enable routes SPI onto segment pins
// - SPI flag set by hardware, cleared writing zero
// - Read-only count to next second, 1/256 units
// - Six-bit final summer count, reset zero
// - Five-bit test output select, reset two
// - Fuse select codes 1, 4, 5, 6
// - Readback returns selected fuse, resets zero
// - Enable switches general pins to alternate UART
package mcrb_pkg;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [13:0] IDX_FINAL_SUM   = 14'h2001;
    localparam logic [13:0] IDX_UART_MUX    = 14'h200f;
    localparam logic [13:0] IDX_FRAC_SEC    = 14'h2014;
    localparam logic [13:0] IDX_SPI_ENABLE  = 14'h2070;
    localparam logic [13:0] IDX_SPI_CMD     = 14'h2071;
    localparam logic [13:0] IDX_SPI_ADDR_HI = 14'h2072;
    localparam logic [13:0] IDX_SPI_ADDR_LO = 14'h2073;
    localparam logic [13:0] IDX_ALT_SLOT2   = 14'h2097;
    localparam logic [13:0] IDX_ALT_SLOT89  = 14'h209a;
    localparam logic [13:0] IDX_TEST_SEL    = 14'h20aa;
    localparam logic [13:0] IDX_SPI_FLAG    = 14'h20b1;
    localparam logic [13:0] IDX_INT_STATUS  = 14'h20c0;
    localparam logic [13:0] IDX_INT_MASK    = 14'h20c1;
    localparam logic [13:0] IDX_FRAC_CLEAR  = 14'h20c2;
    localparam logic [13:0] IDX_FUSE_SEL    = 14'h20fd;
    localparam logic [13:0] IDX_FUSE_READ   = 14'h20ff;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_UART_MUX   = 7;
    localparam int BIT_SPI_ENABLE = 7;
    localparam int BIT_SPI_FLAG   = 4;
    localparam int BIT_INT_SPI    = 0;
    localparam int BIT_INT_SECOND = 1;
    localparam int BIT_FRAC_CLEAR = 0;
    localparam int SLOT9_LSB      = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [5:0] RST_FINAL_SUM = 6'h00;
    localparam logic [3:0] RST_ALT_SLOT2 = 4'hb;
    localparam logic [3:0] RST_ALT_SLOT8 = 4'h8;
    localparam logic [3:0] RST_ALT_SLOT9 = 4'h9;
    localparam logic [4:0] RST_TEST_SEL  = 5'h02;
    localparam logic [3:0] RST_FUSE_SEL  = 4'h0;
    localparam logic [7:0] RST_FUSE_READ = 8'h00;

    // ------------------------------------------------------------
    // Encodings and counts
    // ------------------------------------------------------------
    localparam logic [3:0] SLOT_CODE_MAX  = 4'hb;
    localparam logic [3:0] FUSE_REF_MAG   = 4'h1;
    localparam logic [3:0] FUSE_TEMP_COMP = 4'h4;
    localparam logic [3:0] FUSE_BANDGAP_A = 4'h5;
    localparam logic [3:0] FUSE_BANDGAP_B = 4'h6;
    localparam logic [7:0] FRAC_RELOAD    = 8'hff;
    localparam int         INT_BITS       = 2;

endpackage

//--- design/mcrb_top.sv
// Miscellaneous configuration and status register bank with APB slave
`timescale 1ns/1ps

module mcrb_top #(
    parameter int ADDR_W = 16
) (
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    // APB slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic [31:0]            prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    output logic                   irq_o,
    // SPI engine capture
    input  wire logic              spi_done_i,
    input  wire logic [7:0]        spi_command_i,
    input  wire logic [15:0]       spi_transaction_address_i,
    output logic                   spi_port_enable_o,
    // Real-time clock ticks
    input  wire logic              second_tick_i,
    input  wire logic              fraction_tick_i,
    output logic [7:0]             fraction_second_remaining_o,
    // Converter controls
    output logic [5:0]             final_sum_count_o,
    output logic [3:0]             alt_slot2_input_select_o,
    output logic [3:0]             alt_slot8_input_select_o,
    output logic [3:0]             alt_slot9_input_select_o,
    // Test output
    input  wire logic [31:0]       test_signals_i,
    output logic                   test_output_pin_o,
    // Fuses
    input  wire logic [7:0]        reference_magnitude_fuse_i,
    input  wire logic [2:0]        temp_compensation_fuse_i,
    input  wire logic              bandgap_fuse_a_i,
    input  wire logic              bandgap_fuse_b_i,
    // Optical UART pin multiplexer
    input  wire logic              alt_uart_transmit_i,
    input  wire logic              gpio_out_8_i,
    input  wire logic              general_pin_9_i,
    output logic                   general_pin_8_o,
    output logic                   alt_uart_receive_o
);
    import mcrb_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0]         prdata_r;
    logic                pready_r;
    logic                pslverr_r;
    logic                irq_r;
    logic [5:0]          final_sum_count_r;
    logic                optical_uart_mux_enable_r;
    logic                spi_port_enable_r;
    logic [7:0]          spi_command_byte_r;
    logic [15:0]         spi_address_r;
    logic                spi_event_flag_r;
    logic [3:0]          alt_slot2_r;
    logic [3:0]          alt_slot8_r;
    logic [3:0]          alt_slot9_r;
    logic [4:0]          test_output_select_r;
    logic                test_output_pin_r;
    logic [3:0]          fuse_select_r;
    logic [7:0]          fuse_readback_r;
    logic [7:0]          fraction_r;
    logic                fraction_second_clear_r;
    logic [INT_BITS-1:0] int_status_r;
    logic [INT_BITS-1:0] int_mask_r;
    logic                rx_s1_r;
    logic                rx_s2_r;
    logic                rx_s3_r;
    logic                rx_r;
    logic                general_pin_8_r;
    logic                alt_uart_receive_r;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [13:0]         idx;
    logic                setup;
    logic                wr_en;
    logic                hit;
    logic [31:0]         rd_nxt;
    logic [INT_BITS-1:0] events;
    logic [7:0]          fuse_nxt;

    assign idx   = paddr_i[15:2];
    assign setup = psel_i && !penable_i;
    // Writes land only at the access edge that carries pready high
    assign wr_en = psel_i && penable_i && pready_r && pwrite_i
                   && !pslverr_r;

    // Read mux; also flags unmapped addresses
    always_comb begin
        rd_nxt = 32'h0000_0000;
        hit    = 1'b1;
        case (idx)
            IDX_FINAL_SUM:   rd_nxt[5:0] = final_sum_count_r;
            IDX_UART_MUX:
                rd_nxt[BIT_UART_MUX] = optical_uart_mux_enable_r;
            IDX_FRAC_SEC:    rd_nxt[7:0] = fraction_r;
            IDX_SPI_ENABLE:
                rd_nxt[BIT_SPI_ENABLE] = spi_port_enable_r;
            IDX_SPI_CMD:     rd_nxt[7:0] = spi_command_byte_r;
            IDX_SPI_ADDR_HI: rd_nxt[7:0] = spi_address_r[15:8];
            IDX_SPI_ADDR_LO: rd_nxt[7:0] = spi_address_r[7:0];
            IDX_ALT_SLOT2:   rd_nxt[3:0] = alt_slot2_r;
            IDX_ALT_SLOT89: begin
                rd_nxt[3:0] = alt_slot8_r;
                rd_nxt[7:4] = alt_slot9_r;
            end
            IDX_TEST_SEL:    rd_nxt[4:0] = test_output_select_r;
            IDX_SPI_FLAG:    rd_nxt[BIT_SPI_FLAG] = spi_event_flag_r;
            IDX_INT_STATUS:  rd_nxt[INT_BITS-1:0] = int_status_r;
            IDX_INT_MASK:    rd_nxt[INT_BITS-1:0] = int_mask_r;
            IDX_FRAC_CLEAR:
                rd_nxt[BIT_FRAC_CLEAR] = fraction_second_clear_r;
            IDX_FUSE_SEL:    rd_nxt[3:0] = fuse_select_r;
            IDX_FUSE_READ:   rd_nxt[7:0] = fuse_readback_r;
            default:         hit = 1'b0;
        endcase
        if (paddr_i[1:0] != 2'b00) begin
            hit = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // APB answer: one wait-free access phase after each setup
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r <= setup;
            if (setup) begin
                pslverr_r <= !hit;
                prdata_r  <= (hit && !pwrite_i) ? rd_nxt : 32'h0000_0000;
            end else if (pready_r) begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            final_sum_count_r         <= RST_FINAL_SUM;
            optical_uart_mux_enable_r <= 1'b0;
            spi_port_enable_r         <= 1'b0;
            test_output_select_r      <= RST_TEST_SEL;
            fuse_select_r             <= RST_FUSE_SEL;
            int_mask_r                <= '0;
            fraction_second_clear_r   <= 1'b0;
        end else if (wr_en) begin
            case (idx)
                IDX_FINAL_SUM:
                    final_sum_count_r <= pwdata_i[5:0];
                IDX_UART_MUX:
                    optical_uart_mux_enable_r <=
                        pwdata_i[BIT_UART_MUX];
                IDX_SPI_ENABLE:
                    spi_port_enable_r <= pwdata_i[BIT_SPI_ENABLE];
                IDX_TEST_SEL:
                    test_output_select_r <= pwdata_i[4:0];
                IDX_FUSE_SEL:  fuse_select_r <= pwdata_i[3:0];
                IDX_INT_MASK:  int_mask_r <= pwdata_i[INT_BITS-1:0];
                IDX_FRAC_CLEAR:
                    fraction_second_clear_r <=
                        pwdata_i[BIT_FRAC_CLEAR];
                default: ;
            endcase
        end
    end

    // Slot selects; codes above 11 are refused so a mux state never
    // points at an input that does not exist
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            alt_slot2_r <= RST_ALT_SLOT2;
            alt_slot8_r <= RST_ALT_SLOT8;
            alt_slot9_r <= RST_ALT_SLOT9;
        end else if (wr_en) begin
            if (idx == IDX_ALT_SLOT2 && pwdata_i[3:0] <= SLOT_CODE_MAX) begin
                alt_slot2_r <= pwdata_i[3:0];
            end
            if (idx == IDX_ALT_SLOT89) begin
                if (pwdata_i[3:0] <= SLOT_CODE_MAX) begin
                    alt_slot8_r <= pwdata_i[3:0];
                end
                if (pwdata_i[SLOT9_LSB+3:SLOT9_LSB] <= SLOT_CODE_MAX) begin
                    alt_slot9_r <= pwdata_i[SLOT9_LSB+3:SLOT9_LSB];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // SPI capture and event flag
    // ------------------------------------------------------------
    // Held until the next completed transaction overwrites them
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            spi_command_byte_r <= 8'h00;
            spi_address_r      <= 16'h0000;
        end else if (spi_done_i) begin
            spi_command_byte_r <= spi_command_i;
            spi_address_r      <= spi_transaction_address_i;
        end
    end

    // Set beats a same-cycle clear so no event is lost
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            spi_event_flag_r <= 1'b0;
        end else if (spi_done_i) begin
            spi_event_flag_r <= 1'b1;
        end else if (wr_en && idx == IDX_SPI_FLAG
                     && !pwdata_i[BIT_SPI_FLAG]) begin
            spi_event_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sub-second countdown
    // ------------------------------------------------------------
    // Reloads at each second boundary, steps down per 1/256 tick
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fraction_r <= 8'h00;
        end else if (fraction_second_clear_r) begin
            fraction_r <= 8'h00;
        end else if (second_tick_i) begin
            fraction_r <= FRAC_RELOAD;
        end else if (fraction_tick_i && fraction_r != 8'h00) begin
            fraction_r <= fraction_r - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, write one to clear, set wins
    // ------------------------------------------------------------
    assign events[BIT_INT_SPI]    = spi_done_i;
    assign events[BIT_INT_SECOND] = second_tick_i;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            int_status_r <= '0;
            irq_r        <= 1'b0;
        end else begin
            if (wr_en && idx == IDX_INT_STATUS) begin
                int_status_r <= (int_status_r & ~pwdata_i[INT_BITS-1:0])
                                | events;
            end else begin
                int_status_r <= int_status_r | events;
            end
            irq_r <= |(int_status_r & int_mask_r);
        end
    end

    // ------------------------------------------------------------
    // Fuse readback and test output
    // ------------------------------------------------------------
    always_comb begin
        case (fuse_select_r)
            FUSE_REF_MAG:   fuse_nxt = reference_magnitude_fuse_i;
            FUSE_TEMP_COMP: fuse_nxt = {5'h00, temp_compensation_fuse_i};
            FUSE_BANDGAP_A: fuse_nxt = {7'h00, bandgap_fuse_a_i};
            FUSE_BANDGAP_B: fuse_nxt = {7'h00, bandgap_fuse_b_i};
            default:        fuse_nxt = 8'h00;
        endcase
    end

    // Readback lags a select change by one cycle; bus setup covers it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fuse_readback_r   <= RST_FUSE_READ;
            test_output_pin_r <= 1'b0;
        end else begin
            fuse_readback_r   <= fuse_nxt;
            test_output_pin_r <= test_signals_i[test_output_select_r];
        end
    end

    // ------------------------------------------------------------
    // Optical UART pin multiplexer
    // ------------------------------------------------------------
    // Receive pin is asynchronous; a change counts once stages agree
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_s3_r <= 1'b1;
            rx_r    <= 1'b1;
        end else begin
            rx_s1_r <= general_pin_9_i;
            rx_s2_r <= rx_s1_r;
            rx_s3_r <= rx_s2_r;
            if (rx_s2_r == rx_s3_r) begin
                rx_r <= rx_s3_r;
            end
        end
    end

    // Idle-high receive when the alternate function is off
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            general_pin_8_r    <= 1'b0;
            alt_uart_receive_r <= 1'b1;
        end else begin
            general_pin_8_r    <= optical_uart_mux_enable_r
                                  ? alt_uart_transmit_i : gpio_out_8_i;
            alt_uart_receive_r <= optical_uart_mux_enable_r
                                  ? rx_r : 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata_o                    = prdata_r;
    assign pready_o                    = pready_r;
    assign pslverr_o                   = pslverr_r;
    assign irq_o                       = irq_r;
    assign spi_port_enable_o           = spi_port_enable_r;
    assign fraction_second_remaining_o = fraction_r;
    assign final_sum_count_o           = final_sum_count_r;
    assign alt_slot2_input_select_o    = alt_slot2_r;
    assign alt_slot8_input_select_o    = alt_slot8_r;
    assign alt_slot9_input_select_o    = alt_slot9_r;
    assign test_output_pin_o           = test_output_pin_r;
    assign general_pin_8_o             = general_pin_8_r;
    assign alt_uart_receive_o          = alt_uart_receive_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_spi_flag_set: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) spi_done_i |=> spi_event_flag_r)
        else $error("SPI flag not set after event");

    a_spi_flag_hold: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) spi_event_flag_r
        && !(wr_en && idx == IDX_SPI_FLAG) |=> spi_event_flag_r)
        else $error("SPI flag dropped without a write");

    a_spi_capture: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) spi_done_i
        |=> spi_address_r == $past(spi_transaction_address_i)
        && spi_command_byte_r == $past(spi_command_i))
        else $error("SPI capture wrong");

    a_spi_held: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) !spi_done_i |=> $stable(spi_address_r)
        && $stable(spi_command_byte_r))
        else $error("SPI capture changed without event");

    a_frac_clear: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) fraction_second_clear_r |=> fraction_r == 8'h00)
        else $error("Fraction count not cleared");

    a_frac_reload: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) second_tick_i && !fraction_second_clear_r
        |=> fraction_r == FRAC_RELOAD)
        else $error("Fraction count not reloaded");

    a_slot_range: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) alt_slot2_r <= SLOT_CODE_MAX
        && alt_slot8_r <= SLOT_CODE_MAX && alt_slot9_r <= SLOT_CODE_MAX)
        else $error("Slot select out of range");

    a_fuse_read: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) fuse_select_r == FUSE_REF_MAG
        && $stable(fuse_select_r)
        |=> fuse_readback_r == $past(reference_magnitude_fuse_i))
        else $error("Fuse readback wrong");
    a_uart_route: assert property (@(posedge clk_i)
        disable iff (!rst_b_i) optical_uart_mux_enable_r
        |=> general_pin_8_o == $past(alt_uart_transmit_i))
        else $error("UART transmit not routed");
    a_apb_answer: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        setup |=> pready_o ##1 !pready_o)
        else $error("APB answer timing wrong");
    c_spi_event: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        spi_done_i ##1 spi_event_flag_r ##[1:60] !spi_event_flag_r);
    c_irq: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(irq_o));
    c_frac_count: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        second_tick_i ##[1:50] fraction_tick_i);

endmodule

//--- tb/tb.sv
// Self-checking testbench for the configuration register bank
`timescale 1ns/1ps
module tb;
    import mcrb_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, done = 1'b0;
    logic        st = 1'b0, ft = 1'b0, tx = 1'b0, g8 = 1'b0, p9 = 1'b1;
    logic [15:0] paddr = 16'h0000, sa = 16'h0000;
    logic [31:0] pwd = 32'h0, ts = 32'h0, prd, rd;
    logic [7:0]  cmd = 8'h00, frac;
    logic [5:0]  fsum;
    logic [3:0]  s2, s8, s9;
    logic        prdy, perr, irq, spi_port_enable, tp, p8, rx, err;
    int          fails = 0, num_checks = 0, cyc = 0;

    // Fuse levels are static straps, so they are the only tied inputs
    mcrb_top mcrb_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd),
        .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .irq_o(irq),
        .spi_done_i(done), .spi_command_i(cmd),
        .spi_transaction_address_i(sa), .spi_port_enable_o(spi_port_enable),
        .second_tick_i(st), .fraction_tick_i(ft),
        .fraction_second_remaining_o(frac), .final_sum_count_o(fsum),
        .alt_slot2_input_select_o(s2), .alt_slot8_input_select_o(s8),
        .alt_slot9_input_select_o(s9), .test_signals_i(ts),
        .test_output_pin_o(tp), .reference_magnitude_fuse_i(8'ha5),
        .temp_compensation_fuse_i(3'h5), .bandgap_fuse_a_i(1'b0),
        .bandgap_fuse_b_i(1'b1), .alt_uart_transmit_i(tx),
        .gpio_out_8_i(g8), .general_pin_9_i(p9), .general_pin_8_o(p8),
        .alt_uart_receive_o(rx));

    always #10 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Holds the request until pready is seen; never assumes a latency
    task automatic apb(input logic w, input logic [13:0] idx,
                       input logic [31:0] d);
        @(posedge clk_i);
        psel  <= 1'b1;
        pwr   <= w;
        paddr <= {idx, 2'b00};
        pwd   <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (prdy !== 1'b1);
        rd  = prd;
        err = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    task automatic rc(input logic [13:0] idx, input logic [31:0] e);
        apb(1'b0, idx, 32'h0);
        chk(rd, e);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rc(IDX_FINAL_SUM, 32'h0);
        rc(IDX_TEST_SEL, 32'h2);
        rc(IDX_ALT_SLOT89, 32'h98);
        rc(IDX_FUSE_READ, 32'h0);
        chk(32'({spi_port_enable, rx, p8, s2}), 32'h2b);
    endtask
    task automatic t_regs;
        apb(1'b1, IDX_FINAL_SUM, 32'h3f);
        rc(IDX_FINAL_SUM, 32'h3f);
        apb(1'b1, IDX_ALT_SLOT89, 32'hac);
        apb(1'b1, IDX_ALT_SLOT2, 32'ha);
        tick(1);
        chk(32'({fsum, s2, s9, s8}), 32'h3faa8);
        apb(1'b1, IDX_TEST_SEL, 32'h1f);
        @(posedge clk_i) ts <= 32'h8000_0000;
        tick(3);
        chk(32'(tp), 32'h1);
        apb(1'b0, 14'h2000, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
    endtask
    task automatic t_spi;
        // Clear any spurious flag before the flag is relied on
        apb(1'b1, IDX_SPI_FLAG, 32'h0);
        rc(IDX_SPI_FLAG, 32'h0);
        @(posedge clk_i) done <= 1'b1;
        cmd <= 8'h3c;
        sa  <= 16'hbeef;
        @(posedge clk_i) done <= 1'b0;
        tick(3);
        chk(32'(irq), 32'h0);
        apb(1'b1, IDX_INT_MASK, 32'h1);
        tick(2);
        chk(32'(irq), 32'h1);
        cmd <= 8'h00;
        sa  <= 16'h0000;
        rc(IDX_SPI_CMD, 32'h3c);
        rc(IDX_SPI_ADDR_HI, 32'hbe);
        rc(IDX_SPI_ADDR_LO, 32'hef);
        apb(1'b1, IDX_SPI_FLAG, 32'h10);
        rc(IDX_SPI_FLAG, 32'h10);
        apb(1'b1, IDX_SPI_FLAG, 32'h0);
        rc(IDX_SPI_FLAG, 32'h0);
        apb(1'b1, IDX_INT_STATUS, 32'h1);
        apb(1'b1, IDX_SPI_ENABLE, 32'h80);
        tick(2);
        chk(32'({irq, spi_port_enable}), 32'h1);
    endtask
    task automatic t_frac;
        @(posedge clk_i) st <= 1'b1;
        @(posedge clk_i) st <= 1'b0;
        rc(IDX_FRAC_SEC, 32'hff);
        @(posedge clk_i) ft <= 1'b1;
        @(posedge clk_i) ft <= 1'b0;
        rc(IDX_FRAC_SEC, 32'hfe);
        apb(1'b1, IDX_FRAC_CLEAR, 32'h1);
        tick(2);
        chk(32'(frac), 32'h0);
        apb(1'b1, IDX_FRAC_CLEAR, 32'h0);
    endtask
    task automatic t_fuse;
        logic [3:0] code [5] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
        logic [7:0] exp [5] = '{8'ha5, 8'h00, 8'h05, 8'h00, 8'h01};
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, IDX_FUSE_SEL, 32'(code[i]));
            rc(IDX_FUSE_READ, 32'(exp[i]));
        end
    endtask
    task automatic t_uart;
        @(posedge clk_i) g8 <= 1'b1;
        tick(3);
        chk(32'({p8, rx}), 32'h3);
        apb(1'b1, IDX_UART_MUX, 32'h80);
        @(posedge clk_i) p9 <= 1'b0;
        tick(8);
        chk(32'({p8, rx}), 32'h0);
    endtask

    // Cycle ceiling well above the roughly 160 cycles the run needs
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            end_sim();
        end
    end

    initial begin
        tick(16);
        rst_b_i <= 1'b1;
        t_reset();
        t_regs();
        t_spi();
        t_frac();
        t_fuse();
        t_uart();
        end_sim();
    end
endmodule
